/* rtl/battery_charge_cycle_control.sv */
/*
 * Charge cycle sequencer with APB register file and setpoint outputs.
 * Assumes comparator inputs arrive asynchronously from analog blocks
 * and that the APB master runs on clk.
 */
// Design decisions made here: the APB register port and the address map.
// Summary of operation
// - Precharge by linear source below short threshold, then switched charging.
// - At float voltage, charge completes when current falls to threshold.
// - Termination acts only while termination enable bit is one.
// - Float code gives 3.50 V plus 20 mV steps, saturating 4.44 V.
// - Charge current code selects one of eight sense voltage limits.
// - Termination code selects 3.3 mV times code plus one.
// - Host programs input limit and weak threshold; both only drive outputs.
// - Input supply current limit is only decoded to input_limit_ma, not enforced here.
// - New cycle when battery drops below float minus recharge offset.
// - New cycle when supply reset clears with weak battery.
// - Control write clearing disable or high impedance starts cycle.
// - On termination stop switching and report ready during presence check.
// - After the check, report done if battery and source remain.
// - At die temperature limit reduce charge current.
// - Turn off rectifier on reverse current beyond limit.
// - Hold supply droop at special charger floor when source limited.
// - Input limit codes mean 100, 500, 800 mA and unlimited.
// - High impedance keeps charger off and blocks both directions.
`timescale 1ns/1ps
`default_nettype none
module battery_charge_cycle_control
#(
	parameter int PRESENCE_CYCLES = charge_pkg::PRESENCE_CYCLES_DEF
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bat_below_short,
	input wire logic bat_at_float,
	input wire logic sense_below_term,
	input wire logic bat_below_recharge,
	input wire logic bat_below_weak,
	input wire logic supply_por_ok,
	input wire logic battery_present,
	input wire logic source_present,
	input wire logic die_at_limit,
	input wire logic rect_reverse,
	input wire logic supply_at_floor,
	output logic precharge_en,
	output logic switcher_en,
	output logic rectifier_en,
	output logic thermal_reduce,
	output logic floor_loop_en,
	output logic path_block,
	output logic [1:0] charge_state,
	output logic [12:0] float_mv,
	output logic [9:0] charge_limit_duv,
	output logic [9:0] term_duv,
	output logic [9:0] input_limit_ma,
	output logic input_unlimited,
	output logic [1:0] weak_battery_threshold
);
	import charge_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	wire logic [SYNC_BITS-1:0] raw_in;
	logic [SYNC_BITS-1:0] sync1_reg;
	logic [SYNC_BITS-1:0] sync2_reg;
	assign raw_in = {bat_below_short, bat_at_float, sense_below_term,
		bat_below_recharge, bat_below_weak, supply_por_ok,
		battery_present, source_present, die_at_limit,
		rect_reverse, supply_at_floor};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_BITS; gi++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (rst)
					{sync2_reg[gi], sync1_reg[gi]} <= 2'b00;
				else if (ce)
					{sync2_reg[gi], sync1_reg[gi]} <=
						{sync1_reg[gi], raw_in[gi]};
			end
		end
	endgenerate
	wire logic s_short, s_float, s_term, s_rech, s_weak, s_por;
	wire logic s_bat, s_src, s_hot, s_rev, s_floor;
	assign {s_short, s_float, s_term, s_rech, s_weak, s_por,
		s_bat, s_src, s_hot, s_rev, s_floor} = sync2_reg;

	// ****************************************
	// APB slave
	// ****************************************
	logic [7:0] control_reg;
	logic [5:0] float_voltage_code;
	logic [2:0] charge_current_code;
	logic [2:0] termination_threshold_code;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	wire logic [31:0] rdata_next;
	phase_e phase_reg;
	phase_e phase_next;
	wire logic access;
	wire logic wr_done;
	wire logic hit_ctrl, hit_volt, hit_curr, hit_stat, hit_any;
	assign access = psel & penable;
	assign wr_done = access & pready_reg & pwrite;
	assign hit_ctrl = (paddr[7:0] == OFS_CONTROL);
	assign hit_volt = (paddr[7:0] == OFS_VOLTAGE);
	assign hit_curr = (paddr[7:0] == OFS_CURRENT);
	assign hit_stat = (paddr[7:0] == OFS_STATUS);
	assign hit_any = (paddr[31:8] == 24'h0) &
		(hit_ctrl | hit_volt | hit_curr | hit_stat);

	assign rdata_next = ~hit_any ? 32'h0 :
		hit_ctrl ? {24'h0, control_reg} :
		hit_volt ? {24'h0, float_voltage_code, 2'b00} :
		hit_curr ? {25'h0, charge_current_code, 1'b0,
		termination_threshold_code} :
		{21'h0, switcher_en, precharge_en, thermal_reduce,
		floor_loop_en, phase_reg, charge_state};

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end
		else if (ce)
		begin
			pready_reg <= access & ~pready_reg;
			pslverr_reg <= access & ~pready_reg & ~hit_any;
			prdata_reg <= (access & ~pready_reg & ~pwrite) ?
				rdata_next : 32'h0;
		end
	end
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	// ****************************************
	// Parameter registers
	// ****************************************
	wire logic wr_ctrl, wr_volt, wr_curr;
	assign wr_ctrl = wr_done & hit_any & hit_ctrl;
	assign wr_volt = wr_done & hit_any & hit_volt;
	assign wr_curr = wr_done & hit_any & hit_curr;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			control_reg <= CONTROL_RST;
			float_voltage_code <= FLOAT_RST;
			charge_current_code <= ICHG_RST;
			termination_threshold_code <= TERMINATION_THRESHOLD_CODE_RST;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				control_reg <= {pwdata[7:1], 1'b0};
			if (wr_volt)
				float_voltage_code <= pwdata[FLOAT_LSB +: 6];
			if (wr_curr)
			begin
				charge_current_code <= pwdata[ICHG_LSB +: 3];
				termination_threshold_code <= pwdata[TERMINATION_THRESHOLD_CODE_LSB +: 3];
			end
		end
	end
	wire logic termination_enable;
	wire logic charger_disable;
	wire logic high_impedance_request;
	wire logic [1:0] input_limit_code;
	assign termination_enable = control_reg[TERM_EN_BIT];
	assign charger_disable = control_reg[DISABLE_BIT];
	assign high_impedance_request = control_reg[HIZ_BIT];
	assign input_limit_code = control_reg[INLIM_LSB +: 2];

	// ****************************************
	// Cycle triggers
	// ****************************************
	logic por_prev_reg;
	wire logic halted;
	wire logic trig_write, trig_por, trig_rech, trig_any;
	assign halted = charger_disable | high_impedance_request | ~s_por;
	assign trig_write = wr_ctrl & s_por & ~pwdata[DISABLE_BIT] &
		~pwdata[HIZ_BIT] & (charger_disable | high_impedance_request);
	assign trig_por = s_por & ~por_prev_reg & s_weak;
	assign trig_rech = (phase_reg == ST_DONE) & s_rech;
	assign trig_any = trig_write | trig_por | trig_rech;

	// ****************************************
	// Phase sequencer
	// ****************************************
	logic [31:0] check_cnt_reg;
	wire logic check_over;
	assign check_over = (check_cnt_reg >= 32'(PRESENCE_CYCLES - 1));
	always_comb
	begin
		phase_next = phase_reg;
		case (phase_reg)
			ST_IDLE:
				phase_next = ST_IDLE;
			ST_PRECHARGE:
				if (~s_short)
					phase_next = ST_FAST;
			ST_FAST:
				if (termination_enable & s_float & s_term)
					phase_next = ST_VERIFY;
			ST_VERIFY:
				if (~s_bat | ~s_src)
					phase_next = ST_IDLE;
				else if (check_over)
					phase_next = ST_DONE;
			ST_DONE:
				phase_next = ST_DONE;
			default:
				phase_next = ST_IDLE;
		endcase
		if (halted & ~trig_write)
			phase_next = ST_IDLE;
		else if (trig_any)
			phase_next = s_short ? ST_PRECHARGE : ST_FAST;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_reg <= ST_IDLE;
			por_prev_reg <= 1'b0;
			check_cnt_reg <= 32'h0;
		end
		else if (ce)
		begin
			phase_reg <= phase_next;
			por_prev_reg <= s_por;
			if (phase_reg == ST_VERIFY && phase_next == ST_VERIFY)
				check_cnt_reg <= check_cnt_reg + 32'h1;
			else
				check_cnt_reg <= 32'h0;
		end
	end

	// ****************************************
	// Setpoint decode and outputs
	// ****************************************
	wire logic [12:0] dec_float;
	wire logic [9:0] dec_ichg, dec_term, dec_inlim;
	wire logic dec_unlim;
	charge_code_decode u_decode (
		.float_voltage_code(float_voltage_code),
		.charge_current_code(charge_current_code),
		.termination_threshold_code(termination_threshold_code),
		.input_limit_code(input_limit_code),
		.float_mv(dec_float),
		.charge_limit_duv(dec_ichg),
		.term_duv(dec_term),
		.input_limit_ma(dec_inlim),
		.input_unlimited(dec_unlim)
	);

	wire logic in_fast;
	wire logic [1:0] state_next;
	assign in_fast = (phase_next == ST_FAST);
	assign state_next = (phase_next == ST_DONE) ? STAT_DONE :
		(phase_next == ST_PRECHARGE || in_fast) ? STAT_CHARGING :
		STAT_READY;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			precharge_en <= 1'b0;
			switcher_en <= 1'b0;
			rectifier_en <= 1'b0;
			thermal_reduce <= 1'b0;
			floor_loop_en <= 1'b0;
			path_block <= 1'b1;
			charge_state <= STAT_READY;
			float_mv <= 13'h0;
			charge_limit_duv <= 10'h0;
			term_duv <= 10'h0;
			input_limit_ma <= 10'h0;
			input_unlimited <= 1'b0;
			weak_battery_threshold <= 2'h0;
		end
		else if (ce)
		begin
			precharge_en <= (phase_next == ST_PRECHARGE);
			switcher_en <= in_fast;
			rectifier_en <= in_fast & ~s_rev;
			thermal_reduce <= in_fast & s_hot;
			floor_loop_en <= in_fast & s_floor;
			path_block <= (high_impedance_request & ~trig_write) |
				(phase_next == ST_IDLE);
			charge_state <= state_next;
			float_mv <= dec_float;
			charge_limit_duv <= dec_ichg;
			term_duv <= dec_term;
			input_limit_ma <= dec_inlim;
			input_unlimited <= dec_unlim;
			weak_battery_threshold <= control_reg[WEAK_LSB +: 2];
		end
	end
endmodule : battery_charge_cycle_control
`default_nettype wire

/* rtl/charge_pkg.sv */
/*
 * Shared constants for the charge cycle controller: register offsets,
 * field positions, reset values, status codes, timing and states.
 * Assumes a 100 MHz clock and a 32-bit APB register bus.
 */
`default_nettype none
package charge_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_VOLTAGE = 8'h04;
	localparam logic [7:0] OFS_CURRENT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int INLIM_LSB = 6;
	localparam int WEAK_LSB = 4;
	localparam int TERM_EN_BIT = 3;
	localparam int DISABLE_BIT = 2;
	localparam int HIZ_BIT = 1;
	localparam int FLOAT_LSB = 2;
	localparam int ICHG_LSB = 4;
	localparam int TERMINATION_THRESHOLD_CODE_LSB = 0;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CONTROL_RST = 8'h08;
	localparam logic [5:0] FLOAT_RST = 6'h02;
	localparam logic [2:0] ICHG_RST = 3'h0;
	localparam logic [2:0] TERMINATION_THRESHOLD_CODE_RST = 3'h0;
	// ****************************************
	// Decode figures
	// ****************************************
	localparam logic [12:0] FLOAT_BASE_MV = 13'd3500;
	localparam logic [12:0] FLOAT_STEP_MV = 13'd20;
	localparam logic [5:0] FLOAT_MAX_CODE = 6'd47;
	localparam logic [9:0] TERM_STEP_DUV = 10'd33;
	// ****************************************
	// Charge state codes
	// ****************************************
	localparam logic [1:0] STAT_READY = 2'h0;
	localparam logic [1:0] STAT_CHARGING = 2'h1;
	localparam logic [1:0] STAT_DONE = 2'h2;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int PRESENCE_TIME_MS = 500;
	localparam int PRESENCE_CYCLES_DEF =
		PRESENCE_TIME_MS * (1000000 / CLK_PERIOD_NS);
	localparam int SYNC_BITS = 11;
	// ****************************************
	// Phase states
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PRECHARGE = 5'b00010,
		ST_FAST = 5'b00100,
		ST_VERIFY = 5'b01000,
		ST_DONE = 5'b10000
	} phase_e;
endpackage : charge_pkg
`default_nettype wire

/* rtl/charge_code_decode.sv */
/*
 * Combinational decode of the programmed codes into setpoints.
 * Assumes codes come straight from the register file.
 */
`timescale 1ns/1ps
`default_nettype none
module charge_code_decode
(
	input wire logic [5:0] float_voltage_code,
	input wire logic [2:0] charge_current_code,
	input wire logic [2:0] termination_threshold_code,
	input wire logic [1:0] input_limit_code,
	output logic [12:0] float_mv,
	output logic [9:0] charge_limit_duv,
	output logic [9:0] term_duv,
	output logic [9:0] input_limit_ma,
	output logic input_unlimited
);
	import charge_pkg::*;

	// ****************************************
	// Setpoint decode
	// ****************************************
	wire logic [5:0] float_sat;
	assign float_sat = (float_voltage_code >= FLOAT_MAX_CODE) ?
		FLOAT_MAX_CODE : float_voltage_code;
	assign float_mv = FLOAT_BASE_MV + FLOAT_STEP_MV * {7'd0, float_sat};

	assign term_duv = TERM_STEP_DUV *
		({7'd0, termination_threshold_code} + 10'd1);

	always_comb
	begin
		case (charge_current_code)
			3'd0: charge_limit_duv = 10'd374;
			3'd1: charge_limit_duv = 10'd442;
			3'd2: charge_limit_duv = 10'd510;
			3'd3: charge_limit_duv = 10'd578;
			3'd4: charge_limit_duv = 10'd714;
			3'd5: charge_limit_duv = 10'd782;
			3'd6: charge_limit_duv = 10'd918;
			default: charge_limit_duv = 10'd986;
		endcase
	end

	always_comb
	begin
		case (input_limit_code)
			2'd0: input_limit_ma = 10'd100;
			2'd1: input_limit_ma = 10'd500;
			2'd2: input_limit_ma = 10'd800;
			default: input_limit_ma = 10'd0;
		endcase
	end
	assign input_unlimited = (input_limit_code == 2'd3);
endmodule : charge_code_decode
`default_nettype wire

/* verification/charge_props.sv */
/* Port-level checks for the charge cycle controller.
 Assumes clk rising edge, rst synchronous active high. */
`timescale 1ns/1ps
`default_nettype none
module charge_props
#(
	parameter int PRESENCE_CYCLES = 20
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rect_reverse,
	input wire logic die_at_limit,
	input wire logic supply_at_floor,
	input wire logic precharge_en,
	input wire logic switcher_en,
	input wire logic rectifier_en,
	input wire logic thermal_reduce,
	input wire logic floor_loop_en,
	input wire logic path_block,
	input wire logic [1:0] charge_state
);
	import charge_pkg::*;
	// ****************************************
	// Checks
	// ****************************************
	int ready_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk)
		if (rst || charge_state != STAT_READY)
			ready_cnt <= 0;
		else if (ce)
			ready_cnt <= ready_cnt + 1;
	sequence apb_access;
		psel && !penable && ce ##1 psel && penable && ce;
	endsequence
	sequence sw_held;
		switcher_en && $past(switcher_en);
	endsequence
	a_pre_excl: assert property (!(precharge_en && switcher_en))
		else $error("precharge and switcher both on");
	a_apb_wait: assert property (apb_access |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rect_off: assert property (rect_reverse[*5] |-> !rectifier_en)
		else $error("rectifier on during reverse current");
	a_thermal_cut: assert property
		(die_at_limit[*5] ##0 sw_held |-> thermal_reduce)
		else $error("no thermal reduction");
	a_floor_loop: assert property
		(supply_at_floor[*5] ##0 sw_held |-> floor_loop_en)
		else $error("floor loop not enabled");
	a_block_off: assert property
		(path_block[*3] |-> !switcher_en && !precharge_en)
		else $error("charging while path blocked");
	a_done_check: assert property
		(charge_state == STAT_DONE && $past(charge_state) == STAT_READY
		|-> ready_cnt >= PRESENCE_CYCLES - 1
		&& ready_cnt <= PRESENCE_CYCLES + 1)
		else $error("presence check length wrong");
	a_no_skip: assert property
		(charge_state == STAT_DONE |-> $past(charge_state) != STAT_CHARGING)
		else $error("done without presence check");
endmodule : charge_props
bind battery_charge_cycle_control charge_props
	#(.PRESENCE_CYCLES(PRESENCE_CYCLES)) charge_props_inst (.clk(clk),
	.rst(rst), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .rect_reverse(rect_reverse),
	.die_at_limit(die_at_limit), .supply_at_floor(supply_at_floor),
	.precharge_en(precharge_en), .switcher_en(switcher_en),
	.rectifier_en(rectifier_en), .thermal_reduce(thermal_reduce),
	.floor_loop_en(floor_loop_en), .path_block(path_block),
	.charge_state(charge_state));
`default_nettype wire

/* verification/battery_model.sv */
/* Battery cell model giving comparator levels to the controller.
 Assumes float_mv from the controller and one clock. */
`timescale 1ns/1ps
`default_nettype none
module battery_model
(
	input wire logic clk,
	input wire logic charging,
	input wire logic drain,
	input wire logic [12:0] float_mv,
	output logic bat_below_short,
	output logic bat_at_float,
	output logic sense_below_term,
	output logic bat_below_recharge,
	output logic bat_below_weak
);
	logic [12:0] v_reg = 13'd2800;
	// Cell charges up to float, drains on demand
	always_ff @(posedge clk)
		if (drain)
			v_reg <= v_reg - 13'd10;
		else if (charging && v_reg < float_mv)
			v_reg <= v_reg + 13'd20;
	assign bat_below_short = v_reg < 13'd3000;
	assign bat_at_float = v_reg >= float_mv;
	assign sense_below_term = bat_at_float;
	assign bat_below_recharge = v_reg + 13'd100 < float_mv;
	assign bat_below_weak = v_reg < 13'd3200;
endmodule : battery_model
`default_nettype wire

/* verification/tb.sv */
/* Self-checking bench for the charge cycle controller.
 Assumes the battery model and bound checker alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import charge_pkg::*;
	localparam int PC = 20;
	logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata;
	logic pready, pslverr, drain = 0, supply_por_ok = 0;
	logic battery_present = 1, source_present = 1, die_at_limit = 0;
	logic rect_reverse = 0, supply_at_floor = 0;
	logic bat_below_short, bat_at_float, sense_below_term;
	logic bat_below_recharge, bat_below_weak, precharge_en, switcher_en;
	logic rectifier_en, thermal_reduce, floor_loop_en, path_block;
	logic input_unlimited;
	logic [1:0] charge_state, weak_battery_threshold;
	logic [12:0] float_mv;
	logic [9:0] charge_limit_duv, term_duv, input_limit_ma;
	logic [9:0] lim[8] = '{374, 442, 510, 578, 714, 782, 918, 986};
	logic [9:0] ma[4] = '{100, 500, 800, 0};
	logic [32:0] exp_q[$];
	int error_cnt = 0, checked = 0, n;
	integer seed = 32'hcd22;
	battery_charge_cycle_control #(.PRESENCE_CYCLES(PC))
		battery_charge_cycle_control_inst (.clk(clk), .rst(rst), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bat_below_short(bat_below_short),
		.bat_at_float(bat_at_float),
		.sense_below_term(sense_below_term),
		.bat_below_recharge(bat_below_recharge),
		.bat_below_weak(bat_below_weak), .supply_por_ok(supply_por_ok),
		.battery_present(battery_present),
		.source_present(source_present), .die_at_limit(die_at_limit),
		.rect_reverse(rect_reverse), .supply_at_floor(supply_at_floor),
		.precharge_en(precharge_en), .switcher_en(switcher_en),
		.rectifier_en(rectifier_en), .thermal_reduce(thermal_reduce),
		.floor_loop_en(floor_loop_en), .path_block(path_block),
		.charge_state(charge_state), .float_mv(float_mv),
		.charge_limit_duv(charge_limit_duv), .term_duv(term_duv),
		.input_limit_ma(input_limit_ma),
		.input_unlimited(input_unlimited),
		.weak_battery_threshold(weak_battery_threshold));
	battery_model battery_model_inst (.clk(clk),
		.charging(precharge_en | switcher_en), .drain(drain),
		.float_mv(float_mv), .bat_below_short(bat_below_short),
		.bat_at_float(bat_at_float), .sense_below_term(sense_below_term),
		.bat_below_recharge(bat_below_recharge),
		.bat_below_weak(bat_below_weak));
	// ****************************************
	// Drivers, scoreboard and checks
	// ****************************************
	always #5 clk = ~clk;
	always @(posedge clk)
		{die_at_limit, rect_reverse, supply_at_floor} <= 3'($random(seed));
	task summarize;
		$display("Checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	always @(posedge clk)
		if (pready === 1'b1)
			chk("apb_response", exp_q.pop_front(), {pslverr, prdata});
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		exp_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : xfer
	task wait_state(input logic [1:0] s, input int lim);
		n = 0;
		while (charge_state !== s && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk("charge_state", s, charge_state);
	endtask : wait_state
	initial
	begin
		#100us;
		error_cnt++;
		summarize();
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk("state_rst", STAT_READY, charge_state);
		chk("block_rst", 1, path_block);
		xfer(0, OFS_CONTROL, 0, 33'h08);
		xfer(0, OFS_VOLTAGE, 0, 33'h08);
		xfer(0, OFS_CURRENT, 0, 33'h0);
		xfer(0, 8'h10, 0, 33'h100000000);
		xfer(1, 8'h14, 32'h5a, 33'h100000000);
		for (int i = 0; i < 64; i++)
		begin
			xfer(1, OFS_VOLTAGE, i << 2, 0);
			chk("float_mv", 3500 + 20 * (i > 47 ? 47 : i), float_mv);
		end
		for (int i = 0; i < 8; i++)
		begin
			xfer(1, OFS_CURRENT, (i << 4) | (7 - i), 0);
			chk("charge_limit", lim[i], charge_limit_duv);
			chk("term_duv", 33 * (8 - i), term_duv);
		end
		for (int i = 0; i < 4; i++)
		begin
			xfer(1, OFS_CONTROL, (i << 6) | ((3 - i) << 4) | 8, 0);
			chk("input_limit", ma[i], input_limit_ma);
			chk("unlimited", i == 3, input_unlimited);
			chk("weak", 3 - i, weak_battery_threshold);
		end
		xfer(0, OFS_CONTROL, 0, 33'hc8);
		xfer(1, OFS_VOLTAGE, 32'h08, 0);
		supply_por_ok <= 1'b1;
		wait_state(STAT_CHARGING, 10);
		chk("precharge", 1, precharge_en);
		wait_state(STAT_READY, 200);
		chk("switch_stop", 0, switcher_en);
		ce <= 1'b0;
		repeat (PC) @(posedge clk);
		ce <= 1'b1;
		chk("ce_hold", STAT_READY, charge_state);
		wait_state(STAT_DONE, 100);
		chk("presence_len", 1, n >= PC - 1 && n <= PC + 1);
		xfer(0, OFS_STATUS, 0, {25'h0, ST_DONE, STAT_DONE});
		xfer(1, OFS_CONTROL, 32'hc0, 0);
		drain <= 1'b1;
		wait_state(STAT_CHARGING, 100);
		drain <= 1'b0;
		repeat (3) @(posedge clk);
		chk("fast_entry", 1, switcher_en);
		repeat (100) @(posedge clk);
		chk("no_term", STAT_CHARGING, charge_state);
		xfer(1, OFS_CONTROL, 32'hc8, 0);
		wait_state(STAT_READY, 50);
		battery_present <= 1'b0;
		repeat (PC + 10) @(posedge clk);
		chk("lost_battery", 1, charge_state !== STAT_DONE);
		battery_present <= 1'b1;
		xfer(1, OFS_CONTROL, 32'hc2, 0);
		chk("hiz_block", 1, path_block);
		xfer(1, OFS_CONTROL, 32'hc0, 0);
		wait_state(STAT_CHARGING, 10);
		chk("hiz_restart", 1, switcher_en);
		xfer(1, OFS_CONTROL, 32'hc4, 0);
		chk("disable_off", 0, switcher_en);
		xfer(1, OFS_CONTROL, 32'hc0, 0);
		wait_state(STAT_CHARGING, 10);
		xfer(1, OFS_CONTROL, 32'hc2, 0);
		chk("hiz_stop", 1, {switcher_en, path_block});
		summarize();
	end
endmodule : tb
`default_nettype wire
